// file: hw/stereo_gain_serial_control.sv
// Serial control port, mute, calibration and power-up of a stereo gain stage
`timescale 1ns/1ns
`include "gain_ctrl_map.svh"
module stereo_gain_serial_control
    import gain_ctrl_pkg::*;
#(
    parameter int unsigned POR_CYCLES = `MS_TO_CYCLES(`POR_TIME_MS),
    parameter int unsigned ZC_CYCLES = `MS_TO_CYCLES(`ZC_TIMEOUT_MS),
    parameter int unsigned CAL_CYCLES = `CAL_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic zero_cross_gate_enable,
    input wire logic mute_n,
    input wire logic supply_low,
    input wire logic right_zero_cross,
    input wire logic left_zero_cross,
    output gain_ctrl_pkg::gain_pair_t gain_applied,
    output logic [7:0] right_tap,
    output logic [7:0] left_tap,
    output gain_ctrl_pkg::analog_ctl_t analog_ctl
);
    import gain_ctrl_pkg::*;

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic [1:0] cs_s, sck_s, sdi_s, zce_s, mute_s, uv_s, rzc_s, lzc_s;
    logic cs_n_q, sck_q, rzc_q, lzc_q;

    // Two flops per pin; only the second stage is used below
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s <= 2'h3;
            sck_s <= 2'h0;
            sdi_s <= 2'h0;
            zce_s <= 2'h0;
            mute_s <= 2'h3;
            uv_s <= 2'h0;
            rzc_s <= 2'h0;
            lzc_s <= 2'h0;
        end else begin
            cs_s <= {cs_s[0], chip_select_n};
            sck_s <= {sck_s[0], shift_clk};
            sdi_s <= {sdi_s[0], serial_in};
            zce_s <= {zce_s[0], zero_cross_gate_enable};
            mute_s <= {mute_s[0], mute_n};
            uv_s <= {uv_s[0], supply_low};
            rzc_s <= {rzc_s[0], right_zero_cross};
            lzc_s <= {lzc_s[0], left_zero_cross};
        end
    end

    // Previous values for edge detection
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            rzc_q <= 1'b0;
            lzc_q <= 1'b0;
        end else begin
            cs_n_q <= cs_s[1];
            sck_q <= sck_s[1];
            rzc_q <= rzc_s[1];
            lzc_q <= lzc_s[1];
        end
    end

    logic selected, sck_rise, sck_fall, cs_rise, rzc_pos, lzc_pos;
    assign selected = !cs_s[1];
    assign sck_rise = selected && sck_s[1] && !sck_q;
    assign sck_fall = selected && !sck_s[1] && sck_q;
    assign cs_rise = cs_s[1] && !cs_n_q;
    // Comparator outputs rising mark positive-slope crossings
    assign rzc_pos = rzc_s[1] && !rzc_q;
    assign lzc_pos = lzc_s[1] && !lzc_q;

    // -----------------------------------------------------------------
    // Power-up, calibration and undervoltage sequencing
    // -----------------------------------------------------------------
    power_state_t pw_q;
    logic [31:0] pw_cnt_q;
    logic mute_prev_q, mute_req, in_reset;
    assign mute_req = mute_prev_q && !mute_s[1];
    assign in_reset = (pw_q == PW_RESET);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mute_prev_q <= 1'b1;
        end else begin
            mute_prev_q <= mute_s[1];
        end
    end

    // Supply dip sends the sequencer back to its reset state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pw_q <= PW_RESET;
            pw_cnt_q <= '0;
        end else if (uv_s[1]) begin
            pw_q <= PW_RESET;
            pw_cnt_q <= '0;
        end else begin
            unique case (pw_q)
                PW_RESET: begin
                    if (pw_cnt_q >= POR_CYCLES - 1) begin
                        pw_q <= PW_CAL;
                        pw_cnt_q <= '0;
                    end else begin
                        pw_cnt_q <= pw_cnt_q + 32'd1;
                    end
                end
                PW_CAL: begin
                    if (pw_cnt_q >= CAL_CYCLES - 1) begin
                        pw_q <= PW_RUN;
                        pw_cnt_q <= '0;
                    end else begin
                        pw_cnt_q <= pw_cnt_q + 32'd1;
                    end
                end
                PW_RUN: begin
                    if (mute_req) begin
                        pw_q <= PW_CAL;
                        pw_cnt_q <= '0;
                    end
                end
                default: begin
                    pw_q <= PW_RESET;
                    pw_cnt_q <= '0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Serial shift register
    // -----------------------------------------------------------------
    logic [15:0] shift_q;
    logic out_q;

    // MSB first: new bit enters at bit 0, right code ends up high
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_q <= '0;
        end else if (in_reset) begin
            shift_q <= '0;
        end else if (sck_rise) begin
            shift_q <= {shift_q[14:0], sdi_s[1]};
        end
    end

    // Output updates on falling edge so next device samples stable data
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out_q <= 1'b0;
        end else if (in_reset) begin
            out_q <= 1'b0;
        end else if (sck_fall) begin
            out_q <= shift_q[`WORD_BITS-1];
        end
    end

    assign serial_out = out_q;
    assign serial_out_oe = selected;

    // -----------------------------------------------------------------
    // Holding registers and per-channel apply
    // -----------------------------------------------------------------
    // Last 16 bits in the chain belong to this device
    gain_pair_t hold;
    assign hold.right = shift_q[`RIGHT_MSB:`RIGHT_LSB];
    assign hold.left = shift_q[`LEFT_MSB:`LEFT_LSB];

    logic load, clr_gain, zc_gate, r_pend, l_pend;
    assign load = cs_rise && (pw_q == PW_RUN);
    assign clr_gain = (pw_q != PW_RUN);
    assign zc_gate = zce_s[1];

    channel_gain_apply #(.TIMEOUT_CYCLES(ZC_CYCLES)) u_right (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clear(clr_gain),
        .load(load),
        .code(hold.right),
        .zc_gate(zc_gate),
        .zc_pos(rzc_pos),
        .applied_q(gain_applied.right),
        .pending(r_pend)
    );

    channel_gain_apply #(.TIMEOUT_CYCLES(ZC_CYCLES)) u_left (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clear(clr_gain),
        .load(load),
        .code(hold.left),
        .zc_gate(zc_gate),
        .zc_pos(lzc_pos),
        .applied_q(gain_applied.left),
        .pending(l_pend)
    );

    // -----------------------------------------------------------------
    // Tap decode
    // -----------------------------------------------------------------
    // Tap index = code; gain dB = 31.5 - 0.5*(255-code); zero = unity
    function automatic logic [7:0] tap_of(input logic [7:0] c);
        tap_of = (c == `GAIN_MUTE_CODE) ? 8'hC0 : c;
    endfunction

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            right_tap <= 8'hC0;
            left_tap <= 8'hC0;
        end else begin
            right_tap <= tap_of(gain_applied.right);
            left_tap <= tap_of(gain_applied.left);
        end
    end

    // -----------------------------------------------------------------
    // Hardware mute engage: crossing on either channel or timeout
    // -----------------------------------------------------------------
    logic hw_mute_q, mute_wait_q;
    logic [31:0] mute_cnt_q;

    // Crossing gating here ignores the zero-cross enable input
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hw_mute_q <= 1'b1;
            mute_wait_q <= 1'b0;
            mute_cnt_q <= '0;
        end else if (pw_q != PW_RUN) begin
            hw_mute_q <= 1'b1;
            mute_wait_q <= 1'b0;
            mute_cnt_q <= '0;
        end else if (!mute_s[1] && !hw_mute_q) begin
            if (rzc_pos || lzc_pos || mute_cnt_q >= ZC_CYCLES - 1) begin
                hw_mute_q <= 1'b1;
                mute_wait_q <= 1'b0;
                mute_cnt_q <= '0;
            end else begin
                mute_wait_q <= 1'b1;
                mute_cnt_q <= mute_cnt_q + 32'd1;
            end
        end else if (mute_s[1]) begin
            hw_mute_q <= 1'b0;
            mute_wait_q <= 1'b0;
            mute_cnt_q <= '0;
        end
    end

    // Outside run the mute must already stand when calibration shows busy
    logic mute_now;
    assign mute_now = hw_mute_q || (pw_q != PW_RUN);

    // Analog switch controls, registered to avoid glitching the switches
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_ctl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end else begin
            analog_ctl.right_mute <= mute_now;
            analog_ctl.left_mute <= mute_now;
            analog_ctl.right_gnd <= (gain_applied.right == 8'h00);
            analog_ctl.left_gnd <= (gain_applied.left == 8'h00);
            analog_ctl.out_term <= mute_now;
            analog_ctl.cal_busy <= (pw_q == PW_CAL);
        end
    end
endmodule // stereo_gain_serial_control

// file: hw/gain_ctrl_map.svh
// Offsets, reset values and timing counts of the stereo gain control block
`ifndef GAIN_CTRL_MAP_SVH
`define GAIN_CTRL_MAP_SVH
`define CLK_HZ 100000000
`define WORD_BITS 16
`define RIGHT_MSB 15
`define RIGHT_LSB 8
`define LEFT_MSB 7
`define LEFT_LSB 0
`define GAIN_RESET 8'h00
`define GAIN_MUTE_CODE 8'h00
`define ZC_TIMEOUT_MS 16
`define POR_TIME_MS 100
`define CAL_CYCLES_DEF 1024
`define MS_TO_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))
`endif

// file: hw/gain_ctrl_pkg.sv
// Types shared by the stereo gain control block
package gain_ctrl_pkg;
    typedef struct packed {
        logic [7:0] right;
        logic [7:0] left;
    } gain_pair_t;
    typedef struct packed {
        logic right_mute;
        logic left_mute;
        logic right_gnd;
        logic left_gnd;
        logic out_term;
        logic cal_busy;
    } analog_ctl_t;
    typedef enum logic [1:0] {
        PW_RESET = 2'b00,
        PW_CAL = 2'b01,
        PW_RUN = 2'b10
    } power_state_t;
endpackage

// file: hw/channel_gain_apply.sv
// One channel: wait for zero crossing or timeout before applying a new gain
`timescale 1ns/1ns
`include "gain_ctrl_map.svh"
module channel_gain_apply #(
    parameter int unsigned TIMEOUT_CYCLES = `MS_TO_CYCLES(`ZC_TIMEOUT_MS)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [7:0] code,
    input wire logic zc_gate,
    input wire logic zc_pos,
    output logic [7:0] applied_q,
    output logic pending
);
    logic [7:0] target_q;
    logic pend_q;
    logic [31:0] tmo_q;
    logic fire;

    // Apply on positive zero crossing or timeout when gated, else at once
    assign fire = pend_q &&
        (!zc_gate || zc_pos || tmo_q >= TIMEOUT_CYCLES - 1);
    assign pending = pend_q;

    // -----------------------------------------------------------------
    // Target and pending state
    // -----------------------------------------------------------------
    // A code differing from the target restarts the timeout, and the wait unless it equals the applied gain
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            target_q <= `GAIN_RESET;
            pend_q <= 1'b0;
            tmo_q <= '0;
        end else if (clear) begin
            target_q <= `GAIN_RESET;
            pend_q <= 1'b0;
            tmo_q <= '0;
        end else if (load && code != target_q) begin
            target_q <= code;
            pend_q <= (code != applied_q);
            tmo_q <= '0;
        end else if (fire) begin
            pend_q <= 1'b0;
            tmo_q <= '0;
        end else if (pend_q) begin
            tmo_q <= tmo_q + 32'd1;
        end
    end

    // Applied gain follows target only at the chosen instant
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            applied_q <= `GAIN_RESET;
        end else if (clear) begin
            applied_q <= `GAIN_RESET;
        end else if (fire) begin
            applied_q <= target_q;
        end
    end
endmodule // channel_gain_apply

// file: sim/gain_ctrl_asserts.sv
// Port checker for the stereo gain serial control block
`timescale 1ns/1ns
module gain_ctrl_asserts
    import gain_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic zero_cross_gate_enable,
    input wire logic mute_n,
    input wire logic supply_low,
    input wire logic right_zero_cross,
    input wire logic left_zero_cross,
    input wire gain_ctrl_pkg::gain_pair_t gain_applied,
    input wire logic [7:0] right_tap,
    input wire logic [7:0] left_tap,
    input wire gain_ctrl_pkg::analog_ctl_t analog_ctl
);
    // ----------------------------------------
    // Single clock domain
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Sync delay is two flops, so five samples leave margin
    a_oe_idle: assert property (chip_select_n [*5] |-> !serial_out_oe)
        else $error("serial_out_oe high while deselected");
    a_oe_active: assert property (!chip_select_n [*5] |-> serial_out_oe)
        else $error("serial_out_oe low while selected");
    // Edge seen about three cycles late; low phase lasts eight
    a_out_on_fall: assert property (!$stable(serial_out) |-> !$past(shift_clk, 2))
        else $error("serial_out moved outside a falling edge");
    a_right_zero: assert property (gain_applied.right == 8'h00 |=>
        analog_ctl.right_gnd && right_tap == 8'hC0)
        else $error("right zero code not grounded at unity");
    a_left_zero: assert property (gain_applied.left == 8'h00 |=>
        analog_ctl.left_gnd && left_tap == 8'hC0)
        else $error("left zero code not grounded at unity");
    a_cal_term: assert property (analog_ctl.cal_busy |-> analog_ctl.out_term)
        else $error("outputs live during calibration");
    // Two sync flops, sequencer and output register: five samples
    a_uv_term: assert property (supply_low [*5] |->
        analog_ctl.out_term && !analog_ctl.cal_busy)
        else $error("undervoltage left outputs live");
    a_mute_cal: assert property ($fell(mute_n) && !analog_ctl.out_term |->
        ##[1:6] analog_ctl.cal_busy)
        else $error("hardware mute did not calibrate");
    // Ungated loads only follow a deselect
    a_load_edge: assert property (!$stable(gain_applied) &&
        !zero_cross_gate_enable |-> $past(chip_select_n, 1))
        else $error("gain changed while selected");
endmodule // gain_ctrl_asserts

bind stereo_gain_serial_control gain_ctrl_asserts i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .chip_select_n(chip_select_n), .shift_clk(shift_clk),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe),
    .zero_cross_gate_enable(zero_cross_gate_enable),
    .mute_n(mute_n), .supply_low(supply_low),
    .right_zero_cross(right_zero_cross),
    .left_zero_cross(left_zero_cross), .gain_applied(gain_applied),
    .right_tap(right_tap), .left_tap(left_tap), .analog_ctl(analog_ctl)
);

// file: sim/host_port_model.sv
// Host side of the serial control port, timed by delays
`timescale 1ns/1ns
module host_port_model (
    output logic chip_select_n,
    output logic shift_clk,
    output logic serial_in,
    input wire logic serial_out
);
    logic [31:0] seen_q;
    // Idle: deselected, clock parked low between frames
    initial begin
        chip_select_n = 1'b1;
        shift_clk = 1'b0;
        serial_in = 1'b0;
        seen_q = 32'h0;
    end
    // One frame of n bits; keep_hi shifts with select left high
    task automatic send(input logic [31:0] w, input int n,
                        input logic keep_hi);
        #3;
        chip_select_n = keep_hi;
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #80;
            seen_q = {seen_q[30:0], serial_out};
            shift_clk = 1'b1;
            #80;
            shift_clk = 1'b0;
        end
        #40;
        chip_select_n = 1'b1;
        serial_in = ~serial_in; // Released line shows no stale bit
    endtask
endmodule // host_port_model

// file: sim/stereo_gain_serial_control_test.sv
// Self-checking bench for the stereo gain serial control block
`timescale 1ns/1ns
module stereo_gain_serial_control_test;
    import gain_ctrl_pkg::*;
    typedef struct packed {logic [15:0] w; logic [15:0] g;} row_t;
    localparam int MUTE_LOW = 2000; // Shortened like the other counts
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic zero_cross_gate_enable = 1'b0;
    logic mute_n = 1'b1;
    logic supply_low = 1'b0;
    logic left_zero_cross = 1'b0;
    logic right_zero_cross = 1'b0;
    wire logic [7:0] right_tap, left_tap;
    wire logic chip_select_n, shift_clk, serial_in;
    wire logic serial_out, serial_out_oe;
    gain_pair_t gain_applied;
    analog_ctl_t analog_ctl;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [15:0] prev;
    row_t rows [5] = '{'{16'hFF01, 16'hFF01}, '{16'h0000, 16'h0000},
        '{16'h00FF, 16'h00FF}, '{16'h8000, 16'h8000},
        '{16'h7E81, 16'h7E81}};
    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;
    stereo_gain_serial_control #(.POR_CYCLES(200), .ZC_CYCLES(100),
        .CAL_CYCLES(20)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .chip_select_n(chip_select_n), .shift_clk(shift_clk),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .zero_cross_gate_enable(zero_cross_gate_enable),
        .mute_n(mute_n), .supply_low(supply_low),
        .right_zero_cross(right_zero_cross),
        .left_zero_cross(left_zero_cross),
        .gain_applied(gain_applied), .right_tap(right_tap),
        .left_tap(left_tap),
        .analog_ctl(analog_ctl));
    host_port_model i_host (.chip_select_n(chip_select_n),
        .shift_clk(shift_clk), .serial_in(serial_in),
        .serial_out(serial_out));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Run takes about 60 us; four times that means a hang
    initial begin
        #240000;
        n_mismatch++;
        test_done;
    end
    // Main sequence
    initial begin
        cyc(20);
        sys_rst = 1'b0;
        cyc(2);
        chk(analog_ctl, 16'h003E);
        cyc(208);
        chk(analog_ctl.cal_busy, 1'b1);
        cyc(90);
        chk(gain_applied, 16'h0000);
        prev = 16'h0000;
        foreach (rows[i]) begin
            i_host.send({16'h0000, rows[i].w}, 16, 1'b0);
            cyc(8);
            chk(gain_applied, rows[i].g);
            chk(right_tap, (rows[i].g[15:8] == 8'h00) ? 8'hC0 :
                rows[i].g[15:8]);
            chk(left_tap, (rows[i].g[7:0] == 8'h00) ? 8'hC0 :
                rows[i].g[7:0]);
            chk(i_host.seen_q[15:0], prev);
            prev = rows[i].w;
        end
        // Clocks with select high must leave everything untouched
        i_host.send(32'h00001234, 16, 1'b1);
        cyc(8);
        chk(gain_applied, prev);
        i_host.send(32'h0000ABCD, 16, 1'b0);
        cyc(8);
        chk(i_host.seen_q[15:0], prev);
        // Two-device frame: last word stays, first passes through
        i_host.send(32'h5A5A3C3C, 32, 1'b0);
        cyc(8);
        chk(gain_applied, 16'h3C3C);
        chk(i_host.seen_q[31:16], 16'hABCD);
        chk(i_host.seen_q[15:0], 16'h5A5A);
        // Gated change: left on its crossing, right on timeout
        zero_cross_gate_enable = 1'b1;
        i_host.send(32'h00001122, 16, 1'b0);
        cyc(10);
        chk(gain_applied, 16'h3C3C);
        left_zero_cross = 1'b1;
        cyc(10);
        left_zero_cross = 1'b0;
        chk(gain_applied, 16'h3C22);
        cyc(100);
        chk(gain_applied, 16'h1122);
        zero_cross_gate_enable = 1'b0;
        mute_n = 1'b0;
        cyc(8);
        chk(analog_ctl.cal_busy, 1'b1);
        cyc(MUTE_LOW);
        chk(analog_ctl.out_term, 1'b1);
        mute_n = 1'b1;
        cyc(150);
        chk(analog_ctl.out_term, 1'b0);
        supply_low = 1'b1;
        cyc(10);
        chk(analog_ctl.out_term, 1'b1);
        supply_low = 1'b0;
        cyc(300);
        chk(gain_applied, 16'h0000);
        chk(analog_ctl.out_term, 1'b0);
        test_done;
    end
endmodule // stereo_gain_serial_control_test
